/* File: rtl/pixel_packer_pkg.sv */
// Shared constants, layouts and carrier types for the pixel packer
package pixel_packer_pkg;
  localparam int LINK_WORD_BITS = 32;
  localparam int ACC_BITS       = 48;
  localparam int PIXEL_BITS     = 16;
  localparam int STREAM_COUNT   = 2;
  // Supported dense packing widths
  localparam logic [4:0] PACK_W8  = 5'h08;
  localparam logic [4:0] PACK_W10 = 5'h0a;
  localparam logic [4:0] PACK_W12 = 5'h0c;
  localparam logic [4:0] PACK_W14 = 5'h0e;
  localparam logic [4:0] PACK_W16 = 5'h10;
  // Tap geometry code field positions
  localparam int TAP_INDEX_LSB  = 12;
  localparam int TAP_RSVD_LSB   = 10;
  localparam int ZONE_COUNT_LSB = 6;
  localparam int LINE_GROUP_LSB = 2;
  localparam int EXTRACTOR_LSB  = 0;
  // Field values, N-1 coded
  localparam logic [3:0] FIELD_ONE     = 4'h0;
  localparam logic [3:0] FIELD_TWO     = 4'h1;
  localparam logic [1:0] EXTRACT_TOP   = 2'h0;
  localparam logic [1:0] EXTRACT_EDGES = 2'h1;
  localparam logic [15:0] TAP_GEOMETRY_CODE_RESET   = 16'h0000;
  localparam logic [23:0] WPL_RESET    = 24'h000000;

  typedef enum logic [1:0] {
    single_tap_layout    = 2'h0,
    two_line_tap_layout  = 2'h1,
    two_zone_edge_layout = 2'h2
  } tap_layout_t;

  typedef enum logic [1:0] {
    PACKING  = 2'b00,
    FLUSHING = 2'b01
  } pack_state_t;

  typedef struct packed {
    logic [PIXEL_BITS-1:0] data;      // Right-justified raw value
    logic                  lineEnd;   // Last pixel of the line
    logic                  tap;       // Source tap or image index
  } pixel_in_t;

  typedef struct packed {
    logic [LINK_WORD_BITS-1:0] data;
    logic                      last;  // Final word of a line
  } link_word_t;
endpackage : pixel_packer_pkg

/* File: rtl/pixel_word_packer.sv */
// Dense packer of one stream's pixels into 32-bit link words
`timescale 1ns/1ps
`default_nettype none
module pixel_word_packer (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic [4:0]                pixelBits,
  input  wire logic [23:0]               wordsPerLine,
  input  wire pixel_packer_pkg::pixel_in_t pixelIn,
  input  wire logic                      pixelValid,
  output logic                           pixelReady,
  output var pixel_packer_pkg::link_word_t wordOut,
  output logic                           wordValid,
  input  wire logic                      wordReady
);
  import pixel_packer_pkg::*;

  // Smallest supported width at or above a raw pixel width
  function automatic logic [4:0] packWidthOf(input logic [4:0] bits);
    if (bits <= PACK_W8) return PACK_W8;
    else if (bits <= PACK_W10) return PACK_W10;
    else if (bits <= PACK_W12) return PACK_W12;
    else if (bits <= PACK_W14) return PACK_W14;
    else return PACK_W16;
  endfunction : packWidthOf

  logic [ACC_BITS-1:0]   acc;
  logic [5:0]            fill;
  pack_state_t           state;
  logic [4:0]            packW;
  logic [15:0]           aligned;
  logic [15:0]           lowMask;
  logic [ACC_BITS-1:0]   sum;
  logic [5:0]            newFill;
  logic                  take;
  logic                  canLoad;
  logic                  emit;
  logic                  emitLast;
  logic [LINK_WORD_BITS-1:0] emitData;
  logic [ACC_BITS-1:0]   next_acc;
  logic [5:0]            next_fill;
  pack_state_t           next_state;
  logic [23:0]           lineWordCount;

  assign packW   = packWidthOf(pixelBits);
  assign lowMask = 16'hffff >> (5'h10 - (packW - pixelBits));
  // Raw value MSB-aligned into the packing width, low bits left zero
  assign aligned = (pixelIn.data & (16'hffff >> (5'h10 - pixelBits))) << (packW - pixelBits);
  assign canLoad = !wordValid || wordReady;
  // Ready waits on the link so nothing is dropped under back-pressure
  assign pixelReady = (state == PACKING) && canLoad;
  assign take    = pixelValid && pixelReady;
  // Next value lands just above the filled bits, in arrival order
  assign sum     = acc | (ACC_BITS'(aligned) << fill);
  assign newFill = fill + 6'(packW);

  // Packing decisions
  always_comb begin
    emit       = 1'b0;
    emitLast   = 1'b0;
    emitData   = acc[LINK_WORD_BITS-1:0];
    next_acc   = acc;
    next_fill  = fill;
    next_state = state;
    unique case (state)
      PACKING: begin
        if (take) begin
          if (newFill >= 6'(LINK_WORD_BITS)) begin
            emit      = 1'b1;
            emitData  = sum[LINK_WORD_BITS-1:0];
            emitLast  = pixelIn.lineEnd && (newFill == 6'(LINK_WORD_BITS));
            next_acc  = sum >> LINK_WORD_BITS;
            next_fill = newFill - 6'(LINK_WORD_BITS);
            if (pixelIn.lineEnd && newFill != 6'(LINK_WORD_BITS)) begin
              next_state = FLUSHING;
            end
          end else if (pixelIn.lineEnd) begin
            // Short final word: bits above fill are already zero
            emit      = 1'b1;
            emitData  = sum[LINK_WORD_BITS-1:0];
            emitLast  = 1'b1;
            next_acc  = '0;
            next_fill = 6'h00;
          end else begin
            next_acc  = sum;
            next_fill = newFill;
          end
        end
      end
      FLUSHING: begin
        // Leftover bits of the line go out padded, never shared with the next line
        if (canLoad) begin
          emit       = 1'b1;
          emitLast   = 1'b1;
          next_acc   = '0;
          next_fill  = 6'h00;
          next_state = PACKING;
        end
      end
      default: next_state = PACKING;
    endcase
  end

  // Accumulator and state
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc   <= '0;
      fill  <= 6'h00;
      state <= PACKING;
    end else begin
      acc   <= next_acc;
      fill  <= next_fill;
      state <= next_state;
    end
  end

  // Output word register, held while the link stalls
  always_ff @(posedge mclk) begin
    if (reset) begin
      wordValid <= 1'b0;
      wordOut   <= '0;
    end else if (emit) begin
      wordValid    <= 1'b1;
      wordOut.data <= emitData;
      wordOut.last <= emitLast;
    end else if (wordReady) begin
      wordValid <= 1'b0;
    end
  end

  // Words handed over in the current line, for checking the announced count
  always_ff @(posedge mclk) begin
    if (reset) begin
      lineWordCount <= 24'h000000;
    end else if (wordValid && wordReady) begin
      lineWordCount <= wordOut.last ? 24'h000000 : lineWordCount + 24'h000001;
    end
  end

  line_fresh_a: assert property (@(posedge mclk) disable iff (reset)
    wordValid && wordOut.last |-> fill == 6'h00 && state == PACKING)
    else $error("Line end left bits in the accumulator");
  flush_pad_a: assert property (@(posedge mclk) disable iff (reset)
    state == FLUSHING |-> fill < 6'h10 && (acc >> fill) == '0)
    else $error("Unused bits of final word not zero");
  fill_step_a: assert property (@(posedge mclk) disable iff (reset)
    take && !pixelIn.lineEnd && newFill < 6'h20 |=> fill == $past(newFill))
    else $error("Fill did not advance by the packing width");
  msb_align_a: assert property (@(posedge mclk) disable iff (reset)
    take |-> (aligned & lowMask) == 16'h0000 || packW == pixelBits)
    else $error("Padded pixel has nonzero low bits");
  stall_hold_a: assert property (@(posedge mclk) disable iff (reset)
    wordValid && !wordReady |=> wordValid && $stable(wordOut) && !$past(take))
    else $error("Word changed or pixel taken under back-pressure");
  line_count_a: assert property (@(posedge mclk) disable iff (reset)
    wordValid && wordReady && wordOut.last |-> lineWordCount + 24'h000001 == wordsPerLine)
    else $error("Packed words per line differ from announced count");
  flush_seen_c: cover property (@(posedge mclk) disable iff (reset) state == FLUSHING ##1 state == PACKING);
  stall_seen_c: cover property (@(posedge mclk) disable iff (reset) wordValid && !wordReady ##1 wordValid && wordReady);
  short_end_c: cover property (@(posedge mclk) disable iff (reset) take && pixelIn.lineEnd && newFill < 6'h20);
endmodule : pixel_word_packer
`default_nettype wire

/* File: rtl/image_pixel_packer_tap_streams.sv */
// Top of the pixel packer: tap routing, tap geometry codes and per-stream packers
`timescale 1ns/1ps
`default_nettype none
module image_pixel_packer_tap_streams (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire pixel_packer_pkg::tap_layout_t tapLayout,
  input  wire logic [4:0]                    pixelBits,
  input  wire logic [23:0]                   pixelsPerLine,
  input  wire pixel_packer_pkg::pixel_in_t   pixelIn,
  input  wire logic                          pixelValid,
  output logic                               pixelReady,
  output var pixel_packer_pkg::link_word_t   streamWord [2],
  output logic [1:0]                         streamValid,
  input  wire logic [1:0]                    streamReady,
  output logic [15:0]                        tap_geometry_code [2],
  output logic [31:0]                        tapHeaderHighWord [2],
  output logic [31:0]                        tapHeaderLowWord [2],
  output logic [23:0]                        words_per_line
);
  import pixel_packer_pkg::*;

  // Same width mapping the packers use, needed for the word count
  function automatic logic [4:0] packWidthOf(input logic [4:0] bits);
    if (bits <= PACK_W8) return PACK_W8;
    else if (bits <= PACK_W10) return PACK_W10;
    else if (bits <= PACK_W12) return PACK_W12;
    else if (bits <= PACK_W14) return PACK_W14;
    else return PACK_W16;
  endfunction : packWidthOf

  // Tap geometry code from layout and the stream's tap number
  function automatic logic [15:0] tapCodeOf(input tap_layout_t layout, input logic tapNum);
    logic [3:0] stream_tap_index;
    logic [3:0] vertical_zone_count;
    logic [3:0] vertical_line_group;
    logic [1:0] extractor_placement;
    stream_tap_index    = (layout == single_tap_layout) ? FIELD_ONE : {3'h0, tapNum};
    vertical_zone_count = (layout == two_zone_edge_layout) ? FIELD_TWO : FIELD_ONE;
    vertical_line_group = (layout == two_line_tap_layout) ? FIELD_TWO : FIELD_ONE;
    extractor_placement = (layout == two_zone_edge_layout) ? EXTRACT_EDGES : EXTRACT_TOP;
    return (16'(stream_tap_index) << TAP_INDEX_LSB) | (16'(vertical_zone_count) << ZONE_COUNT_LSB)
         | (16'(vertical_line_group) << LINE_GROUP_LSB) | (16'(extractor_placement) << EXTRACTOR_LSB);
  endfunction : tapCodeOf

  logic        routeTap;
  logic [1:0]  laneReady;
  logic [29:0] lineBits;

  // A single-tap setting sends everything to stream 0, whatever the source says
  assign routeTap   = (tapLayout == single_tap_layout) ? 1'b0 : pixelIn.tap;
  assign pixelReady = laneReady[routeTap];
  assign lineBits   = 30'(pixelsPerLine) * 30'(packWidthOf(pixelBits));

  // One independent packer per tap or image, each with its own line state
  for (genvar g = 0; g < STREAM_COUNT; g++) begin : gen_stream
    pixel_word_packer packer (
      .mclk         (mclk),
      .reset        (reset),
      .pixelBits    (pixelBits),
      .wordsPerLine (words_per_line),
      .pixelIn      (pixelIn),
      .pixelValid   (pixelValid && routeTap == 1'(g)),
      .pixelReady   (laneReady[g]),
      .wordOut      (streamWord[g]),
      .wordValid    (streamValid[g]),
      .wordReady    (streamReady[g])
    );

    // Code for this stream held in a net, since a function result cannot be sliced
    logic [15:0] codeNow;
    assign codeNow = tapCodeOf(tapLayout, 1'(g));

    // Header fields registered per stream; bytes repeated across four lanes
    always_ff @(posedge mclk) begin
      if (reset) begin
        tap_geometry_code[g] <= TAP_GEOMETRY_CODE_RESET;
        tapHeaderHighWord[g] <= {4{TAP_GEOMETRY_CODE_RESET[15:8]}};
        tapHeaderLowWord[g]  <= {4{TAP_GEOMETRY_CODE_RESET[7:0]}};
      end else begin
        tap_geometry_code[g] <= codeNow;
        tapHeaderHighWord[g] <= {4{codeNow[15:8]}};
        tapHeaderLowWord[g]  <= {4{codeNow[7:0]}};
      end
    end
  end

  // Announced words per line, rounded up to whole words
  always_ff @(posedge mclk) begin
    if (reset) begin
      words_per_line <= WPL_RESET;
    end else begin
      words_per_line <= 24'((lineBits + 30'h1f) >> 5);
    end
  end

  code_values_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 $past(tapLayout) == two_zone_edge_layout && !$past(reset)
    |-> tap_geometry_code[0] == 16'h0041 && tap_geometry_code[1] == 16'h1041)
    else $error("Two-zone edge codes wrong");
  code_line_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 $past(tapLayout) == two_line_tap_layout && !$past(reset)
    |-> tap_geometry_code[0] == 16'h0004 && tap_geometry_code[1] == 16'h1004)
    else $error("Two-line codes wrong");
  code_single_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 $past(tapLayout) == single_tap_layout && !$past(reset) |-> tap_geometry_code[0] == 16'h0000)
    else $error("Single tap code wrong");
  rsvd_bits_a: assert property (@(posedge mclk) disable iff (reset)
    tap_geometry_code[1][11:10] == 2'h0 && tap_geometry_code[0][15:13] == 3'h0)
    else $error("Reserved code bits set");
  header_bytes_a: assert property (@(posedge mclk) disable iff (reset)
    tapHeaderHighWord[1] == {4{tap_geometry_code[1][15:8]}} && tapHeaderLowWord[1][31:24] == tap_geometry_code[1][7:0])
    else $error("Header words do not match code");
  single_route_a: assert property (@(posedge mclk) disable iff (reset)
    tapLayout == single_tap_layout && !streamValid[1] |=> !streamValid[1])
    else $error("Single tap did not route to stream 0");
  both_taps_c: cover property (@(posedge mclk) disable iff (reset) streamValid == 2'b11);
  edge_layout_c: cover property (@(posedge mclk) disable iff (reset)
    tapLayout == two_zone_edge_layout && pixelValid && pixelReady && pixelIn.tap);
endmodule : image_pixel_packer_tap_streams
`default_nettype wire

/* File: verif/frame_grabber_model.sv */
// Host frame grabber model: takes link words with optional stalls and tallies words per line
`timescale 1ns/1ps
`default_nettype none
module frame_grabber_model (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic                          stallOn,
  input  wire logic [1:0]                    streamValid,
  input  var  pixel_packer_pkg::link_word_t  streamWord [2],
  output logic [1:0]                         streamReady,
  output logic [23:0]                        lineWords [2]
);
  import pixel_packer_pkg::*;
  logic [15:0] lfsr;
  logic [23:0] count [2];
  // Uneven backpressure from an LFSR, so the packer must hold words and stall its input
  always_ff @(posedge mclk) begin
    if (reset) begin
      lfsr        <= 16'hace1;
      streamReady <= 2'h0;
    end else begin
      lfsr        <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      streamReady <= stallOn ? lfsr[1:0] : 2'h3;
    end
  end
  // Words per finished line, to be held against the announced count
  always_ff @(posedge mclk) begin
    for (int s = 0; s < 2; s++) begin
      if (reset) begin
        count[s]     <= 24'h000000;
        lineWords[s] <= 24'h000000;
      end else if (streamValid[s] && streamReady[s]) begin
        count[s] <= streamWord[s].last ? 24'h000000 : count[s] + 24'h000001;
        if (streamWord[s].last) begin
          lineWords[s] <= count[s] + 24'h000001;
        end
      end
    end
  end
endmodule : frame_grabber_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the tap-stream pixel packer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pixel_packer_pkg::*;
  logic        mclk          = 1'b0;
  logic        reset         = 1'b1;
  tap_layout_t tapLayout     = single_tap_layout;
  logic [4:0]  pixelBits     = 5'h08;
  logic [23:0] pixelsPerLine = 24'h000001;
  pixel_in_t   pixelIn       = '0;
  logic        pixelValid    = 1'b0;
  logic        stallOn       = 1'b0;
  logic        pixelReady;
  link_word_t  streamWord [2];
  logic [1:0]  streamValid;
  logic [1:0]  streamReady;
  logic [15:0] tap_geometry_code [2];
  logic [31:0] tapHeaderHighWord [2];
  logic [31:0] tapHeaderLowWord [2];
  logic [23:0] words_per_line;
  logic [23:0] lineWords [2];
  link_word_t  expQ [2][$];
  logic [63:0] acc [2]  = '{64'h0, 64'h0};
  int          fill [2] = '{0, 0};
  int          bad_count = 0;
  int          checked   = 0;
  int          cycles    = 0;
  int          stalls    = 0;
  logic [31:0] seed      = 32'h0000002c;
  logic [15:0] codeTab [3][2] = '{'{16'h0000, 16'h0000}, '{16'h0004, 16'h1004}, '{16'h0041, 16'h1041}};

  image_pixel_packer_tap_streams dut_u (.mclk(mclk), .reset(reset), .tapLayout(tapLayout), .pixelBits(pixelBits),
    .pixelsPerLine(pixelsPerLine), .pixelIn(pixelIn), .pixelValid(pixelValid), .pixelReady(pixelReady),
    .streamWord(streamWord), .streamValid(streamValid), .streamReady(streamReady),
    .tap_geometry_code(tap_geometry_code), .tapHeaderHighWord(tapHeaderHighWord),
    .tapHeaderLowWord(tapHeaderLowWord), .words_per_line(words_per_line));
  frame_grabber_model host_u (.mclk(mclk), .reset(reset), .stallOn(stallOn), .streamValid(streamValid),
    .streamWord(streamWord), .streamReady(streamReady), .lineWords(lineWords));

  // Free-running 200 MHz clock
  always #2.5 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Odd widths round up to the next even width, never below eight
  function automatic int pack_w(input logic [4:0] b);
    return (b <= 5'h08) ? 8 : ((int'(b) + 1) / 2) * 2;
  endfunction : pack_w

  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  task automatic check_word(input string nm, input link_word_t e, input link_word_t g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word

  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Offer one pixel and note the words it should produce; holds until taken
  task automatic drive(input logic tp, input logic le);
    logic [15:0] v;
    logic        rdy;
    int          s;
    int          pw;
    v  = 16'(rnd() & ((32'h1 << pixelBits) - 32'h1));
    s  = (tapLayout == single_tap_layout) ? 0 : int'(tp);
    pw = pack_w(pixelBits);
    pixelIn    <= '{data: v, lineEnd: le, tap: tp};
    pixelValid <= 1'b1;
    acc[s] = acc[s] | (64'(v) << (pw - int'(pixelBits) + fill[s]));
    fill[s] += pw;
    if (fill[s] >= 32) begin
      expQ[s].push_back({acc[s][31:0], le && fill[s] == 32});
      acc[s] = acc[s] >> 32;
      fill[s] -= 32;
    end
    if (le && fill[s] > 0) begin
      expQ[s].push_back({acc[s][31:0], 1'b1});
      acc[s]  = 64'h0;
      fill[s] = 0;
    end
    do begin
      @(negedge mclk);
      rdy = pixelReady;
      stalls += (rdy === 1'b1) ? 0 : 1;
      @(posedge mclk);
    end while (rdy !== 1'b1 && cycles < 20000);
  endtask : drive

  // One line per stream in use, then drain and check the line word counts
  task automatic run_line(input int n, input logic twoTaps);
    int k;
    int wpl;
    @(posedge mclk);
    pixelsPerLine <= 24'(n);
    wpl = (n * pack_w(pixelBits) + 31) / 32;
    for (int i = 0; i < n; i++) begin
      drive(twoTaps ? 1'b0 : rnd() % 2 == 1, i == n - 1);
      if (twoTaps) begin
        drive(1'b1, i == n - 1);
      end
    end
    pixelValid <= 1'b0;
    for (k = 0; k < 300 && expQ[0].size() + expQ[1].size() != 0; k++) @(posedge mclk);
    @(negedge mclk);
    check_val("queue left", 0, expQ[0].size() + expQ[1].size());
    check_val("words per line", 32'(wpl), {8'h00, words_per_line});
    check_val("line words 0", 32'(wpl), {8'h00, lineWords[0]});
    if (twoTaps) begin
      check_val("line words 1", 32'(wpl), {8'h00, lineWords[1]});
    end
    // Hand back on a rising edge so the caller's settings change there
    @(posedge mclk);
  endtask : run_line

  // Every accepted word is set against the oldest noted one of its stream
  always @(negedge mclk) begin
    for (int s = 0; s < 2; s++) begin
      if (!reset && streamValid[s] === 1'b1 && streamReady[s] === 1'b1) begin
        check_word("stream word", expQ[s].size() != 0 ? expQ[s].pop_front() : 'x, streamWord[s]);
      end
    end
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int l = 0; l < 3; l++) begin
      tapLayout <= tap_layout_t'(l);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check_val("code 0", {16'h0, codeTab[l][0]}, {16'h0, tap_geometry_code[0]});
      check_val("header high", {4{codeTab[l][0][15:8]}}, tapHeaderHighWord[0]);
      check_val("header low", {4{codeTab[l][0][7:0]}}, tapHeaderLowWord[0]);
      if (l != 0) begin
        check_val("code 1", {16'h0, codeTab[l][1]}, {16'h0, tap_geometry_code[1]});
        check_val("header high 1", {4{codeTab[l][1][15:8]}}, tapHeaderHighWord[1]);
        check_val("header low 1", {4{codeTab[l][1][7:0]}}, tapHeaderLowWord[1]);
      end
      @(posedge mclk);
    end
    tapLayout <= single_tap_layout;
    for (int w = 8; w <= 16; w++) begin
      for (int r = 0; r < 3; r++) begin
        pixelBits <= 5'(w);
        stallOn   <= r[0];
        run_line(1 + int'(rnd() % 9), 1'b0);
      end
    end
    pixelBits <= 5'h08;
    stallOn   <= 1'b0;
    @(posedge mclk);
    stalls = 0;
    run_line(8, 1'b0);
    check_val("stall cycles", 0, stalls);
    stallOn <= 1'b1;
    for (int l = 1; l < 3; l++) begin
      tapLayout <= tap_layout_t'(l);
      pixelBits <= (l == 1) ? 5'h0a : 5'h0d;
      run_line(2 + int'(rnd() % 6), 1'b1);
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
